// File: design/exc_unit.sv
// Exception state tracker: pending/active bits, nesting, fixed and configurable priority
// Assumes the core presents fault causes as one-cycle pulses and ends a handler with exc_return
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Exception stays active until handler completes
// - Nested handlers keep both exceptions active
// - Same-source request while active sets pending
// - Reset is a special exception
// - Reset halts everything immediately
// - After reset, fetch from reset vector
// - After reset, privileged thread mode
// - NMI from peripheral or software, priority -2
// - NMI never masked, only reset preempts
// - Hard fault on escalation, priority -1
// - Protection faults when memory_protection_unit is set, and execute-never fetch abort
// - Bus errors raise bus fault
// - Fixed usage fault causes always reported
// - Unaligned and divide-by-zero only when enabled
module exc_unit
	import exc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [31:0] vector_base,
	input wire logic nmi_periph,
	input wire logic nmi_soft,
	input wire logic irq_req,
	input wire logic soft_req,
	input wire logic signed [PRIO_W-1:0] mem_prio,
	input wire logic signed [PRIO_W-1:0] bus_prio,
	input wire logic signed [PRIO_W-1:0] usage_prio,
	input wire logic signed [PRIO_W-1:0] irq_prio,
	input wire logic signed [PRIO_W-1:0] soft_prio,
	input wire logic mem_fault_en,
	input wire logic bus_fault_en,
	input wire logic usage_fault_en,
	input wire logic protect_violation,
	input wire logic execute_never_region,
	input wire logic memory_protection_unit,
	input wire logic bus_error,
	input wire logic undef_instr,
	input wire logic illegal_unaligned,
	input wire logic invalid_state,
	input wire logic exc_return_err,
	input wire logic unaligned_access,
	input wire logic div_by_zero,
	input wire logic trap_unaligned,
	input wire logic trap_div0,
	input wire logic exc_return,
	output logic [NUM_EXC-1:0] active_r,
	output logic [NUM_EXC-1:0] pending_r,
	output logic [IDX_W-1:0] current_r,
	output logic take_exc,
	output logic [IDX_W-1:0] take_idx,
	output logic fetch_req_r,
	output logic [31:0] fetch_addr_r,
	output logic privileged_r,
	output logic handler_mode_r,
	output logic halted
);
	core_state_t state_r;
	logic [IDX_W-1:0] stack_r [NUM_EXC];
	logic [IDX_W-1:0] depth_r;
	logic [NUM_EXC-1:0] raise;
	logic [NUM_EXC-1:0] done;
	logic signed [PRIO_W-1:0] cur_prio;
	logic signed [PRIO_W-1:0] best_prio;
	logic [IDX_W-1:0] best_idx;
	logic mem_f, bus_f, use_f, escalate;

	// Configurable priorities never reach the fixed ones: a negative setting counts as zero
	function automatic logic signed [PRIO_W-1:0] cfg_prio(input logic signed [PRIO_W-1:0] p);
		if (p[PRIO_W-1]) begin
			cfg_prio = '0;
		end else begin
			cfg_prio = p;
		end
	endfunction

	// Priority of an exception index
	function automatic logic signed [PRIO_W-1:0] prio_of(input logic [IDX_W-1:0] idx,
		input logic signed [PRIO_W-1:0] pm, input logic signed [PRIO_W-1:0] pb,
		input logic signed [PRIO_W-1:0] pu, input logic signed [PRIO_W-1:0] pi,
		input logic signed [PRIO_W-1:0] ps);
		case (idx)
			EXC_NMI: prio_of = PRIO_NMI;
			EXC_HARD: prio_of = PRIO_HARD;
			EXC_MEM: prio_of = cfg_prio(pm);
			EXC_BUS: prio_of = cfg_prio(pb);
			EXC_USAGE: prio_of = cfg_prio(pu);
			EXC_IRQ: prio_of = cfg_prio(pi);
			EXC_SOFT: prio_of = cfg_prio(ps);
			default: prio_of = PRIO_IDLE;
		endcase
	endfunction

	assign halted = srst || (state_r == CORE_RESET);

	// Fault classification
	always_comb begin
		mem_f = (protect_violation && memory_protection_unit) || execute_never_region;
		bus_f = bus_error;
		use_f = undef_instr || illegal_unaligned || invalid_state || exc_return_err
			|| (unaligned_access && trap_unaligned) || (div_by_zero && trap_div0);
		// unmanageable fault escalates to hard fault
		escalate = (mem_f && (!mem_fault_en || prio_of(EXC_MEM, mem_prio, bus_prio, usage_prio, irq_prio,
			soft_prio) >= cur_prio)) || (bus_f && (!bus_fault_en || cfg_prio(bus_prio) >= cur_prio))
			|| (use_f && (!usage_fault_en || cfg_prio(usage_prio) >= cur_prio)) || (exc_return && depth_r == '0);
		raise = '0;
		raise[EXC_NMI] = nmi_periph || nmi_soft;
		raise[EXC_HARD] = escalate;
		raise[EXC_MEM] = mem_f && !escalate;
		raise[EXC_BUS] = bus_f && !escalate;
		raise[EXC_USAGE] = use_f && !escalate;
		raise[EXC_IRQ] = irq_req;
		raise[EXC_SOFT] = soft_req;
	end

	// Current execution priority
	assign cur_prio = (depth_r == '0) ? PRIO_IDLE
		: prio_of(current_r, mem_prio, bus_prio, usage_prio, irq_prio, soft_prio);

	// lowest priority value wins; ties to lowest index
	always_comb begin
		best_prio = PRIO_IDLE;
		best_idx = EXC_NONE;
		for (int i = 1; i < NUM_EXC; i++) begin
			if (pending_r[i] && prio_of(IDX_W'(i), mem_prio, bus_prio, usage_prio, irq_prio, soft_prio)
				< best_prio) begin
				best_prio = prio_of(IDX_W'(i), mem_prio, bus_prio, usage_prio, irq_prio, soft_prio);
				best_idx = IDX_W'(i);
			end
		end
	end

	// NMI can preempt any handler but its own since nothing else reaches -2
	assign take_exc = (state_r == CORE_RUN) && !srst && ce && (best_idx != EXC_NONE) && (best_prio < cur_prio);
	assign take_idx = best_idx;

	// Completion of the innermost handler
	always_comb begin
		done = '0;
		if (state_r == CORE_RUN && exc_return && depth_r != '0) begin
			done[current_r] = 1'b1;
		end
	end

	// Pending bits: arrival wins over the clear at entry
	always_ff @(posedge clk) begin
		if (srst) begin
			pending_r <= '0;
		end else if (ce && state_r == CORE_RUN) begin
			for (int i = 1; i < NUM_EXC; i++) begin
				// same source while active stays pending
				if (raise[i]) begin
					pending_r[i] <= 1'b1;
				end else if (take_exc && take_idx == IDX_W'(i)) begin
					pending_r[i] <= 1'b0;
				end
			end
		end
	end

	// Active bits and nesting stack
	always_ff @(posedge clk) begin
		if (srst) begin
			active_r <= '0;
			depth_r <= '0;
			current_r <= EXC_NONE;
			for (int i = 0; i < NUM_EXC; i++) begin
				stack_r[i] <= EXC_NONE;
			end
		end else if (ce) begin
			if (take_exc) begin
				active_r[take_idx] <= 1'b1;
				stack_r[depth_r] <= current_r;
				depth_r <= depth_r + 3'h1;
				current_r <= take_idx;
			end else if (|done) begin
				active_r <= active_r & ~done;
				depth_r <= depth_r - 3'h1;
				current_r <= stack_r[depth_r - 3'h1];
			end
		end
	end

	// reset sequence as a special exception
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= CORE_RESET;
			fetch_req_r <= 1'b0;
			fetch_addr_r <= 32'h0000_0000;
		end else if (ce) begin
			fetch_req_r <= 1'b0;
			case (state_r)
				CORE_RESET: begin
					fetch_req_r <= 1'b1;
					fetch_addr_r <= vector_base + RESET_VEC_OFS;
					state_r <= CORE_FETCH;
				end
				CORE_FETCH: state_r <= CORE_RUN;
				CORE_RUN: state_r <= CORE_RUN;
				default: state_r <= CORE_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			privileged_r <= 1'b1;
			handler_mode_r <= 1'b0;
		end else if (ce) begin
			if (take_exc) begin
				handler_mode_r <= 1'b1;
			end else if (|done && depth_r == 3'h1) begin
				handler_mode_r <= 1'b0;
			end
		end
	end

	// Assertions
	a_reset_thread: assert property (@(posedge clk) srst |=> privileged_r && !handler_mode_r && active_r == '0)
		else $error("reset did not enter privileged thread");
	a_reset_vector: assert property (@(posedge clk) disable iff (srst) $rose(fetch_req_r)
		|-> fetch_addr_r == $past(vector_base) + RESET_VEC_OFS)
		else $error("reset fetch address wrong");
	a_halt_reset: assert property (@(posedge clk) srst |-> halted && !take_exc)
		else $error("not halted in reset");
	a_take_active: assert property (@(posedge clk) disable iff (srst) take_exc |=> active_r[$past(take_idx)])
		else $error("taken exception not active");
	a_nest_both: assert property (@(posedge clk) disable iff (srst) take_exc && depth_r != '0 && ce
		|=> active_r[$past(current_r)] && active_r[current_r])
		else $error("nesting lost active state");
	a_same_pend: assert property (@(posedge clk) disable iff (srst) ce && state_r == CORE_RUN && raise[EXC_IRQ]
		&& active_r[EXC_IRQ] |=> pending_r[EXC_IRQ] && active_r[EXC_IRQ])
		else $error("active and pending not held");
	a_nmi_first: assert property (@(posedge clk) disable iff (srst) take_exc && pending_r[EXC_NMI]
		|-> take_idx == EXC_NMI)
		else $error("nmi not taken first");
	a_nmi_raise: assert property (@(posedge clk) disable iff (srst) ce && state_r == CORE_RUN
		&& (nmi_periph || nmi_soft) |=> pending_r[EXC_NMI] || active_r[EXC_NMI])
		else $error("nmi request lost");
	a_hard_before: assert property (@(posedge clk) disable iff (srst) take_exc && pending_r[EXC_HARD]
		&& !pending_r[EXC_NMI] |-> take_idx == EXC_HARD)
		else $error("hard fault not prioritised");
	a_xn_fault: assert property (@(posedge clk) disable iff (srst) execute_never_region |-> raise[EXC_MEM]
		|| raise[EXC_HARD])
		else $error("execute-never fetch not faulted");
	a_bus_fault: assert property (@(posedge clk) disable iff (srst) bus_error |-> raise[EXC_BUS] || raise[EXC_HARD])
		else $error("bus error not faulted");
	a_usage_fix: assert property (@(posedge clk) disable iff (srst) undef_instr |-> raise[EXC_USAGE]
		|| raise[EXC_HARD])
		else $error("undefined instruction not faulted");
	a_usage_cfg: assert property (@(posedge clk) disable iff (srst) div_by_zero && !trap_div0 && !undef_instr
		&& !illegal_unaligned && !invalid_state && !exc_return_err && !(unaligned_access && trap_unaligned)
		&& !(exc_return && depth_r == '0) |-> !use_f)
		else $error("untrapped divide faulted");
	a_prio_order: assert property (@(posedge clk) disable iff (srst) take_exc |-> best_prio
		<= prio_of(EXC_SOFT, mem_prio, bus_prio, usage_prio, irq_prio, soft_prio) || !pending_r[EXC_SOFT])
		else $error("lower priority taken first");
	// Reset clears the exception state and stops the vector fetch
	a_reset_clear: assert property (@(posedge clk) srst
		|=> pending_r == '0 && depth_r == '0 && !fetch_req_r && current_r == EXC_NONE)
		else $error("reset left exception state behind");
	// Reset release: first edge still halted, vector fetch follows
	a_halt_release: assert property (@(posedge clk) $fell(srst) |-> halted)
		else $error("not halted on reset release");
	a_fetch_release: assert property (@(posedge clk) $fell(srst) && ce |=> fetch_req_r)
		else $error("no vector fetch after reset");
	// Thread mode whenever no handler is nested
	a_thread_idle: assert property (@(posedge clk) disable iff (srst) depth_r == '0 |-> !handler_mode_r)
		else $error("handler mode with no active handler");
	// Active bit of a running handler drops only by its own return
	a_active_hold: assert property (@(posedge clk) disable iff (srst) active_r[EXC_IRQ]
		&& !(exc_return && current_r == EXC_IRQ) |=> active_r[EXC_IRQ])
		else $error("active state lost before return");
	// Fixed-priority handlers are preempted only by something more urgent
	a_nmi_held: assert property (@(posedge clk) disable iff (srst) depth_r != '0 && current_r == EXC_NMI
		|-> !take_exc)
		else $error("nmi handler preempted");
	a_hard_held: assert property (@(posedge clk) disable iff (srst) depth_r != '0 && current_r == EXC_HARD
		&& pending_r[EXC_IRQ] |-> !(take_exc && take_idx == EXC_IRQ))
		else $error("hard fault preempted by configurable exception");
	// Of two pending configurable requests the more urgent goes first
	a_prio_best: assert property (@(posedge clk) disable iff (srst) take_exc && pending_r[EXC_SOFT] && pending_r[EXC_IRQ]
		&& cfg_prio(soft_prio) < cfg_prio(irq_prio) |-> take_idx != EXC_IRQ)
		else $error("less urgent request taken first");
	c_nest: cover property (@(posedge clk) take_exc && depth_r != '0);
	c_nmi: cover property (@(posedge clk) take_exc && take_idx == EXC_NMI);
	c_act_pend: cover property (@(posedge clk) active_r[EXC_IRQ] && pending_r[EXC_IRQ]);
	c_hard: cover property (@(posedge clk) take_exc && take_idx == EXC_HARD);
	c_reset_fetch: cover property (@(posedge clk) fetch_req_r);
endmodule

`default_nettype wire

// File: design/exc_pkg.sv
// Package for the exception state tracker: exception numbers, priorities, states
// Assumes one core clock and a synchronous active-high reset
package exc_pkg;
	localparam int NUM_EXC = 8;
	localparam int IDX_W = 3;
	localparam int PRIO_W = 4;
	// Exception indices
	localparam logic [IDX_W-1:0] EXC_NONE = 3'h0;
	localparam logic [IDX_W-1:0] EXC_NMI = 3'h1;
	localparam logic [IDX_W-1:0] EXC_HARD = 3'h2;
	localparam logic [IDX_W-1:0] EXC_MEM = 3'h3;
	localparam logic [IDX_W-1:0] EXC_BUS = 3'h4;
	localparam logic [IDX_W-1:0] EXC_USAGE = 3'h5;
	localparam logic [IDX_W-1:0] EXC_IRQ = 3'h6;
	localparam logic [IDX_W-1:0] EXC_SOFT = 3'h7;
	// Signed priorities: lower value is more urgent
	localparam logic signed [PRIO_W-1:0] PRIO_NMI = -4'sd2;
	localparam logic signed [PRIO_W-1:0] PRIO_HARD = -4'sd1;
	localparam logic signed [PRIO_W-1:0] PRIO_IDLE = 4'sh7;
	// Reset vector entry offset
	localparam logic [31:0] RESET_VEC_OFS = 32'h0000_0004;
	typedef enum logic [1:0] {
		CORE_RESET = 2'b00,
		CORE_FETCH = 2'b01,
		CORE_RUN = 2'b11
	} core_state_t;
endpackage

// File: tb/req_source.sv
// Behavioural source of exception requests: peripherals and core fault causes
// Assumes the bench calls fire() from its own process; each pulse lasts one clock
`timescale 1ns/1ps
`default_nettype none
module req_source (
	output logic [13:0] req,
	input wire logic clk
);
	// Idle: no cause raised
	initial req = 14'h0000;
	// Raise a set of causes for one clock, changed off the sampling edge
	task automatic fire(input logic [13:0] cause);
		@(negedge clk);
		req = cause;
		@(negedge clk);
		req = 14'h0000;
	endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench for the exception state tracker: hand-written scenarios, self-checking
// Assumes req_source drives request and fault pulses; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	import exc_pkg::*;
	localparam logic [13:0] C_NMIP = 14'h2000, C_NMIS = 14'h1000, C_IRQ = 14'h0800, C_SOFT = 14'h0400;
	localparam logic [13:0] C_PROT = 14'h0200, C_EXNV = 14'h0100, C_BUS = 14'h0080, C_UND = 14'h0040;
	localparam logic [13:0] C_ILU = 14'h0020, C_INV = 14'h0010, C_RERR = 14'h0008, C_UNAL = 14'h0004;
	localparam logic [13:0] C_DIV0 = 14'h0002, C_RET = 14'h0001;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [31:0] vector_base = 32'h0000_1000;
	logic signed [PRIO_W-1:0] mem_prio = 4'sh1, bus_prio = 4'sh1, usage_prio = 4'sh1;
	logic signed [PRIO_W-1:0] irq_prio = 4'sh4, soft_prio = 4'sh2;
	logic mem_fault_en = 1'b1, bus_fault_en = 1'b1, usage_fault_en = 1'b1;
	logic memory_protection_unit = 1'b1, trap_unaligned = 1'b0, trap_div0 = 1'b1;
	logic [NUM_EXC-1:0] active_r, pending_r;
	logic [IDX_W-1:0] current_r, take_idx;
	logic take_exc, fetch_req_r, privileged_r, handler_mode_r, halted;
	logic [31:0] fetch_addr_r;
	logic [13:0] req;
	int n_fail = 0, n_checks = 0, cyc = 0;
	logic [13:0] fc [7] = '{C_PROT, C_BUS, C_UND, C_ILU, C_INV, C_RERR, C_DIV0};
	logic [IDX_W-1:0] fi [7] = '{3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5};

	req_source src (.req, .clk);
	exc_unit dut (.clk, .srst, .ce, .vector_base, .nmi_periph(req[13]), .nmi_soft(req[12]), .irq_req(req[11]),
		.soft_req(req[10]), .mem_prio, .bus_prio, .usage_prio, .irq_prio, .soft_prio, .mem_fault_en, .bus_fault_en,
		.usage_fault_en, .protect_violation(req[9]), .execute_never_region(req[8]), .memory_protection_unit,
		.bus_error(req[7]), .undef_instr(req[6]), .illegal_unaligned(req[5]), .invalid_state(req[4]),
		.exc_return_err(req[3]), .unaligned_access(req[2]), .div_by_zero(req[1]), .trap_unaligned, .trap_div0,
		.exc_return(req[0]), .active_r, .pending_r, .current_r, .take_exc, .take_idx, .fetch_req_r, .fetch_addr_r,
		.privileged_r, .handler_mode_r, .halted);

	// Clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Raise a cause, see it taken next cycle and made active the cycle after
	task automatic take(input logic [13:0] c, input logic [IDX_W-1:0] idx);
		src.fire(c); // raise cause
		chk(take_exc, 1); // entry taken
		chk(take_idx, idx); // most urgent chosen
		@(negedge clk);
		chk(current_r, idx); // now running
		chk(active_r[idx], 1); // marked active
		chk(handler_mode_r, 1); // handler mode
	endtask
	// End the innermost handler
	task automatic ret(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] cur);
		src.fire(C_RET); // handler return
		chk(active_r[idx], 0); // no longer active
		chk(current_r, cur); // preempted handler resumes
		chk(handler_mode_r, cur != EXC_NONE); // thread mode when none left
	endtask
	task automatic do_reset();
		srst = 1'b1;
		repeat (3) @(negedge clk);
		src.fire(C_NMIP); // ignored in reset
		repeat (5) @(negedge clk);
		chk(halted, 1); // halted
		chk({active_r, pending_r, current_r}, 0); // state cleared
		chk(privileged_r, 1); // privileged
		srst = 1'b0;
		@(negedge clk);
		chk(fetch_req_r, 1); // vector fetch
		chk(fetch_addr_r, vector_base + RESET_VEC_OFS); // reset entry
		chk(handler_mode_r, 0); // thread mode
		chk(halted, 0); // running after release
		repeat (2) @(negedge clk);
		chk(pending_r, 0); // request dropped
		chk(fetch_req_r, 0); // single vector fetch
		$display("test reset done");
	endtask
	task automatic t_nest();
		take(C_IRQ, 6); // irq entry
		take(C_NMIP, 1); // nmi preempts
		chk(active_r, 8'h42); // both active
		src.fire(C_IRQ); // same source again
		chk(pending_r, 8'h40); // active and pending
		chk(take_exc, 0); // nmi not preempted
		src.fire(C_BUS); // fault under nmi
		chk(take_exc, 0); // hard fault waits
		chk(pending_r[2], 1); // escalated
		ret(1, 6); // nmi done
		chk(take_idx, 2); // hard fault over irq
		@(negedge clk);
		ret(2, 6); // hard done
		ret(6, 0); // irq done
		chk(take_idx, 6); // reserviced
		@(negedge clk);
		ret(6, 0); // irq done
		take(C_NMIS, 1); // software nmi
		ret(1, 0); // nmi done
		$display("test nesting done");
	endtask
	task automatic t_prio();
		take(C_IRQ | C_SOFT, 7); // lower value first
		chk(pending_r, 8'h40); // irq waits
		ret(7, 0); // soft done
		chk(take_idx, 6); // irq next
		@(negedge clk);
		ret(6, 0); // irq done
		$display("test priority done");
	endtask
	task automatic t_faults();
		for (int i = 0; i < 7; i++) begin
			take(fc[i], fi[i]); // fault class
			ret(fi[i], 0); // fault handler done
		end
		memory_protection_unit = 1'b0;
		src.fire(C_PROT | C_UNAL); // masked causes
		chk(take_exc, 0); // not reported
		take(C_EXNV, 3); // execute never
		ret(3, 0); // mem fault done
		trap_unaligned = 1'b1;
		take(C_UNAL, 5); // reported when enabled
		ret(5, 0); // usage fault done
		mem_fault_en = 1'b0;
		take(C_EXNV, 2); // disabled class escalates
		ret(2, 0); // hard fault done
		take(C_IRQ, 6); // irq entry
		$display("test faults done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence; the last reset lands with a handler active
	initial begin
		do_reset(); // power-up reset
		t_nest(); // nesting
		t_prio(); // ordering
		t_faults(); // fault classes
		vector_base = 32'h0000_2000;
		do_reset(); // warm reset mid-handler
		final_report();
	end
endmodule
`default_nettype wire
